// *** rtl/host_bus_endian_defs.svh ***
// Constants for the host bus endian and config access block
// What this block does
// RQ1: Keep one endian bit per index/data pair
// RQ2: Bit three sets endianness of FIFO accesses
// RQ3: Every endian bit mirrored into four lanes
// RQ4: Config reads identical under either endianness
// RQ5: Reserved nibbles read-only, endian bits reset zero
// RQ6: Index and config take direct narrow writes
// RQ7: Write cycle from strobe pair or enable
// RQ8: Write data latched at cycle trailing edge
// RQ9: Write lane from endianness and low address
// RQ10: Host avoids byte writes in 16-bit mode
// RQ11: Writes ignored after init until a read
// RQ12: Writes ignored outside D0 until a read
// RQ13: Read cycle from strobe pair or enable
// RQ14: Read drives addressed lane onto data pins
// RQ15: Address is byte or word by mode
// RQ16: Reserved bits read zero, writes discarded
`ifndef HOST_BUS_ENDIAN_DEFS_SVH
`define HOST_BUS_ENDIAN_DEFS_SVH
// Dword slot of each register, taken from address bits 4:2
`define HB_SLOT_IDX0 3'h0
`define HB_SLOT_IDX1 3'h2
`define HB_SLOT_IDX2 3'h4
`define HB_SLOT_CFG 3'h7
// Reset value of each index register
`define HB_IDX_RESET 16'h1234
// Reset value of the endian bits
`define HB_CFG_RESET 4'h0
// Bit of the FIFO endian selection
`define HB_CFG_FIFO_BIT 3
// Spacing between shadow copies
`define HB_LANE_BITS 8
`endif

// *** rtl/host_bus_endian_pkg.sv ***
// Types shared by the host bus endian and config access block
package host_bus_endian_pkg;
  // Host pins after synchronising, all active high
  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic bus_en;
    logic rnw;
    logic [4:0] addr;
    logic [15:0] data;
  } host_pins_s;
  // Endian selections seen by the rest of the device
  typedef struct packed {
    logic fifo_big;
    logic [2:0] pair_big;
  } endian_cfg_s;
  // Bus cycle tracking
  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_WRITE,
    CYC_READ
  } cyc_e;
endpackage

// *** rtl/host_bus_endian_config_access.sv ***
// Indexed-mode host port: index and endian configuration registers
`timescale 1ns/10ps
`include "host_bus_endian_defs.svh"
module host_bus_endian_config_access (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic cs_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic bus_enable_strobe_n_i,
  input wire logic read_not_write_sel_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic bus_enable_style_i,
  input wire logic bus16_mode_i,
  input wire logic power_d0_i,
  input wire logic init_done_i,
  output logic [15:0] data_o,
  output logic data_oe_n_o,
  output host_bus_endian_pkg::endian_cfg_s endian_cfg_o,
  output logic [47:0] index_regs_o
);

  localparam int PW = $bits(host_bus_endian_pkg::host_pins_s);

  // Raw pin image, polarity normalised to active high
  host_bus_endian_pkg::host_pins_s raw;
  // Three-stage synchroniser chain
  logic [PW-1:0] s1_q;
  logic [PW-1:0] s2_q;
  logic [PW-1:0] s3_q;
  // Filtered pin image and its next value
  logic [PW-1:0] filt_q;
  logic [PW-1:0] filt_d;
  host_bus_endian_pkg::host_pins_s pins;

  assign raw.cs = ~cs_n_i;
  assign raw.wr = ~wr_n_i;
  assign raw.rd = ~rd_n_i;
  assign raw.bus_en = ~bus_enable_strobe_n_i;
  assign raw.rnw = read_not_write_sel_i;
  assign raw.addr = addr_i;
  assign raw.data = data_i;
  assign pins = filt_q;

  // A bit changes only once stages two and three agree
  always_comb begin
    filt_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
  end

  // Synchroniser and filter registers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end else if (clk_en_i) begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  // Cycle qualifiers from the filtered pins
  logic wr_act;
  logic rd_act;
  logic live;

  // Either strobe style, always qualified by chip select
  assign wr_act = pins.cs & (bus_enable_style_i ? (pins.bus_en & ~pins.rnw) : pins.wr); // [RQ7]
  assign rd_act = pins.cs & (bus_enable_style_i ? (pins.bus_en & pins.rnw) : pins.rd); // [RQ13]
  // Port is usable only when initialised and in D0
  assign live = power_d0_i & init_done_i;

  // Map a host byte address to a register byte lane
  function automatic logic [1:0] lane_of(input logic [1:0] b, input logic big);
    lane_of = big ? (2'h3 - b) : b;
  endfunction

  // Register state
  logic [15:0] idx_q [3];
  logic [15:0] idx_d [3];
  logic [3:0] cfg_q;
  logic [3:0] cfg_d;
  // Cycle state, write hold and write gate
  host_bus_endian_pkg::cyc_e cyc_q;
  host_bus_endian_pkg::cyc_e cyc_d;
  logic [4:0] hold_addr_q;
  logic [4:0] hold_addr_d;
  logic [15:0] hold_data_q;
  logic [15:0] hold_data_d;
  logic unlock_q;
  logic unlock_d;
  // Write lane decode
  logic commit;
  logic [1:0] wb;
  logic wbig;
  logic [1:0] wla;
  logic [1:0] wlb;
  logic [3:0] wmask;
  logic [31:0] wval;
  logic [31:0] wbytes;
  logic [31:0] widx;
  logic [2:0] wslot;

  // Next values for the cycle tracker and registers
  always_comb begin
    cyc_d = cyc_q;
    hold_addr_d = hold_addr_q;
    hold_data_d = hold_data_q;
    unlock_d = unlock_q;
    commit = 1'b0;
    idx_d = idx_q;
    cfg_d = cfg_q;
    wslot = hold_addr_q[4:2];
    // Word mode has no address bit 0
    wb = bus16_mode_i ? {hold_addr_q[1], 1'b0} : hold_addr_q[1:0]; // [RQ15]
    wbig = 1'b0;
    case (wslot)
      `HB_SLOT_IDX0: wbig = cfg_q[0];
      `HB_SLOT_IDX1: wbig = cfg_q[1];
      `HB_SLOT_IDX2: wbig = cfg_q[2];
      default: wbig = 1'b0;
    endcase
    wla = lane_of(wb, wbig); // [RQ9]
    wlb = lane_of(wb | 2'h1, wbig); // [RQ9]
    wmask = '0;
    wval = '0;
    wval[{wla, 3'b000} +: 8] = hold_data_q[7:0];
    wmask[wla] = 1'b1;
    // Upper host byte only exists in word mode
    if (bus16_mode_i) begin
      wval[{wlb, 3'b000} +: 8] = hold_data_q[15:8];
      wmask[wlb] = 1'b1;
    end
    wbytes = {{8{wmask[3]}}, {8{wmask[2]}}, {8{wmask[1]}}, {8{wmask[0]}}};
    widx = '0;
    case (cyc_q)
      host_bus_endian_pkg::CYC_IDLE: begin
        // Writes win if both strobes appear together
        if (wr_act) begin
          cyc_d = host_bus_endian_pkg::CYC_WRITE;
        end else if (rd_act) begin
          cyc_d = host_bus_endian_pkg::CYC_READ;
        end
      end
      host_bus_endian_pkg::CYC_WRITE: begin
        if (wr_act) begin
          // Track pins while active; hold time may be zero
          hold_addr_d = pins.addr;
          hold_data_d = pins.data;
        end else begin
          // Trailing edge: store only when the gate is open
          commit = unlock_q & live; // [RQ8] [RQ11] [RQ12]
          cyc_d = host_bus_endian_pkg::CYC_IDLE;
        end
      end
      host_bus_endian_pkg::CYC_READ: begin
        if (!rd_act) begin
          // A completed read opens the write gate
          if (live) begin
            unlock_d = 1'b1; // [RQ11] [RQ12]
          end
          cyc_d = host_bus_endian_pkg::CYC_IDLE;
        end
      end
      default: cyc_d = host_bus_endian_pkg::CYC_IDLE;
    endcase
    // Leaving D0 or losing init closes the gate
    if (!live) begin
      unlock_d = 1'b0; // [RQ12]
    end
    if (commit) begin
      case (wslot)
        `HB_SLOT_IDX0, `HB_SLOT_IDX1, `HB_SLOT_IDX2: begin
          // Direct narrow store, no dword assembly
          widx = {16'h0000, idx_q[wslot[2:1]]};
          widx = (widx & ~wbytes) | (wval & wbytes); // [RQ6]
          // Upper half is reserved and dropped
          idx_d[wslot[2:1]] = widx[15:0]; // [RQ16]
        end
        `HB_SLOT_CFG: begin
          // Any set copy among written lanes sets all four
          for (int k = 0; k < 4; k++) begin
            cfg_d[k] = |{wval[k+24], wval[k+16], wval[k+8], wval[k]}; // [RQ3] [RQ1] [RQ2]
          end
        end
        default: begin
          // Data and FIFO slots are handled elsewhere
          cfg_d = cfg_q;
        end
      endcase
    end
  end

  // Cycle tracker and register file
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cyc_q <= host_bus_endian_pkg::CYC_IDLE;
      hold_addr_q <= '0;
      hold_data_q <= '0;
      unlock_q <= 1'b0;
      idx_q <= '{default: `HB_IDX_RESET};
      cfg_q <= `HB_CFG_RESET; // [RQ5]
    end else if (clk_en_i) begin
      cyc_q <= cyc_d;
      hold_addr_q <= hold_addr_d;
      hold_data_q <= hold_data_d;
      unlock_q <= unlock_d;
      idx_q <= idx_d;
      cfg_q <= cfg_d;
    end
  end

  // Read path: live address selects a register
  logic [31:0] cfg_word;
  logic [31:0] rword;
  logic [1:0] rb;
  logic rbig;
  logic [1:0] rla;
  logic [1:0] rlb;
  logic drive;
  logic [15:0] data_d;
  logic [15:0] data_q;
  logic oe_n_d;
  logic oe_n_q;

  // Each endian nibble shadowed into all lanes, reserved nibbles zero
  assign cfg_word = {4{4'h0, cfg_q}}; // [RQ3] [RQ4] [RQ5] [RQ16]

  // Select and steer the addressed lane
  always_comb begin
    rword = '0;
    rbig = 1'b0;
    case (pins.addr[4:2])
      `HB_SLOT_IDX0: begin
        rword = {16'h0000, idx_q[0]};
        rbig = cfg_q[0];
      end
      `HB_SLOT_IDX1: begin
        rword = {16'h0000, idx_q[1]};
        rbig = cfg_q[1];
      end
      `HB_SLOT_IDX2: begin
        rword = {16'h0000, idx_q[2]};
        rbig = cfg_q[2];
      end
      `HB_SLOT_CFG: rword = cfg_word;
      default: rword = '0;
    endcase
    rb = bus16_mode_i ? {pins.addr[1], 1'b0} : pins.addr[1:0]; // [RQ15]
    rla = lane_of(rb, rbig); // [RQ14]
    rlb = lane_of(rb | 2'h1, rbig); // [RQ14]
    // Reads are ignored outside D0 or before init
    drive = rd_act & live;
    data_d = '0;
    if (drive) begin
      data_d[7:0] = rword[{rla, 3'b000} +: 8]; // [RQ14]
      if (bus16_mode_i) begin
        data_d[15:8] = rword[{rlb, 3'b000} +: 8];
      end
    end
    oe_n_d = ~drive;
  end

  // Data pins are registered to avoid glitches on the bus
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_q <= '0;
      oe_n_q <= 1'b1;
    end else if (clk_en_i) begin
      data_q <= data_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign data_o = data_q;
  assign data_oe_n_o = oe_n_q;
  assign endian_cfg_o.fifo_big = cfg_q[`HB_CFG_FIFO_BIT]; // [RQ2]
  assign endian_cfg_o.pair_big = cfg_q[2:0]; // [RQ1]
  assign index_regs_o = {idx_q[2], idx_q[1], idx_q[0]};

  // Checks run on enabled clock edges only
  default clocking cb @(posedge sys_clk_i iff clk_en_i); endclocking
  default disable iff (!nrst_i);

  // Any config lane read on the pins shows the same endian nibble
  a_shadow_copies_equal: assert property (rd_act && live && pins.addr[4:2] == `HB_SLOT_CFG // [RQ4]
    |=> data_o[3:0] == $past(cfg_q) && (!bus16_mode_i || data_o[11:8] == $past(cfg_q)))
    else $error("config lane read differs from endian bits");
  a_reserved_reads_zero: assert property (rd_act && live && pins.addr[4:2] == `HB_SLOT_CFG // [RQ5]
    |=> (data_o & 16'hF0F0) == 16'h0000)
    else $error("reserved config bits not zero");
  a_gate_closed_hold: assert property (cyc_q == host_bus_endian_pkg::CYC_WRITE && !wr_act && !unlock_q // [RQ11]
    |=> index_regs_o == $past(index_regs_o) && cfg_q == $past(cfg_q))
    else $error("write accepted while gate closed");
  a_not_d0_closes: assert property (!power_d0_i |=> !unlock_q) // [RQ12]
    else $error("write gate open outside D0");
  a_read_opens_gate: assert property (cyc_q == host_bus_endian_pkg::CYC_READ && !rd_act && live |=> unlock_q) // [RQ11]
    else $error("completed read did not open gate");
  a_read_drives_pins: assert property (rd_act && live |=> !data_oe_n_o) // [RQ14]
    else $error("read cycle not driving pins");
  a_no_drive_idle: assert property (!rd_act |=> data_oe_n_o ##1 data_oe_n_o || rd_act) // [RQ13]
    else $error("pins driven outside read");
  a_cfg_byte_sets: assert property (commit && wslot == `HB_SLOT_CFG && !bus16_mode_i && hold_data_q[0] // [RQ3]
    |=> cfg_q[0] && cfg_word[24] && cfg_word[8])
    else $error("set copy did not set all shadows");
  a_trailing_commit: assert property (commit && wslot == `HB_SLOT_IDX0 && !bus16_mode_i && wb == 2'h0 // [RQ8]
    && !cfg_q[0] |=> idx_q[0][7:0] == $past(hold_data_q[7:0]))
    else $error("index byte not stored at trailing edge");

endmodule

// *** verif/host_cpu_model.sv ***
// Host processor model that drives the parallel host pins
`timescale 1ns/10ps
module host_cpu_model (
  input wire logic sys_clk_i,
  input wire logic bus_enable_style_i,
  input wire logic [15:0] data_i,
  input wire logic data_oe_n_i,
  output logic cs_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic bus_enable_strobe_n_o,
  output logic rnw_o,
  output logic [4:0] addr_o,
  output logic [15:0] data_o
);
  // Strobe width and gap, both well past the device pin filter
  localparam int HOLD = 6;
  // Idle bus: every strobe inactive
  initial begin
    {cs_n_o, wr_n_o, rd_n_o, bus_enable_strobe_n_o, rnw_o} = 5'h1F;
    addr_o = 5'h00;
    data_o = 16'h0000;
  end
  // One bus cycle; a write when is_wr is set, otherwise a read
  task automatic access(input logic is_wr, input logic [4:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic oe_n);
    @(posedge sys_clk_i);
    addr_o <= addr;
    data_o <= wdata; // Callers send whole words in 16-bit mode
    rnw_o <= !is_wr;
    cs_n_o <= 1'h0;
    if (bus_enable_style_i) begin
      bus_enable_strobe_n_o <= 1'h0;
    end else if (is_wr) begin
      wr_n_o <= 1'h0;
    end else begin
      rd_n_o <= 1'h0;
    end
    repeat (HOLD) @(posedge sys_clk_i);
    rdata = data_i;
    oe_n = data_oe_n_i;
    {cs_n_o, wr_n_o, rd_n_o, bus_enable_strobe_n_o} <= 4'hF;
    // Released data shows the inverse so a stale value never looks valid
    data_o <= ~wdata;
    repeat (HOLD) @(posedge sys_clk_i);
  endtask
endmodule

// *** verif/host_bus_endian_config_access_test.sv ***
// Self-checking bench for the host port endian and config access block
`timescale 1ns/10ps
module host_bus_endian_config_access_test;
  logic sys_clk_i = 1'h0; // System clock
  logic nrst_i = 1'h0; // Reset, active low
  logic bus16 = 1'h0; // 16-bit data mode
  logic bus_enable_style = 1'h0; // Enable strobe style
  logic power_d0 = 1'h1; // D0 power state
  logic init_done = 1'h0; // Device initialised
  logic cs_n, wr_n, rd_n, bus_enable_strobe_n, rnw, oe_n; // Host pins
  logic [4:0] addr; // Host address
  logic [15:0] wdata, rdata; // Host data both ways
  host_bus_endian_pkg::endian_cfg_s cfg; // Endian selections
  logic [47:0] idx; // Index registers
  int mismatches = 0;
  int check_count = 0;
  // Free running clock
  always #5 sys_clk_i = ~sys_clk_i;
  host_bus_endian_config_access DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(1'h1),
    .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n), .bus_enable_strobe_n_i(bus_enable_strobe_n),
    .read_not_write_sel_i(rnw), .addr_i(addr), .data_i(wdata), .bus_enable_style_i(bus_enable_style),
    .bus16_mode_i(bus16), .power_d0_i(power_d0), .init_done_i(init_done), .data_o(rdata),
    .data_oe_n_o(oe_n), .endian_cfg_o(cfg), .index_regs_o(idx));
  host_cpu_model host (.sys_clk_i(sys_clk_i), .bus_enable_style_i(bus_enable_style), .data_i(rdata),
    .data_oe_n_i(oe_n), .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
    .bus_enable_strobe_n_o(bus_enable_strobe_n),
    .rnw_o(rnw), .addr_o(addr), .data_o(wdata));
  // Compare one result, counting every check
  task automatic check(input string name, input logic [47:0] exp, input logic [47:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Host write cycle
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic o;
    host.access(1'h1, a, d, r, o);
  endtask
  // Host read cycle, judging the data and that the pins were driven
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] r;
    logic o;
    host.access(1'h0, a, 16'h0000, r, o);
    check("read data", {32'h0, exp}, {32'h0, r});
    check("read oe_n", 48'h0, {47'h0, o});
  endtask
  // Values straight out of reset
  task automatic t_reset;
    check("cfg", 48'h0, {44'h0, cfg});
    check("index", {3{16'h1234}}, idx);
    check("idle oe_n", 48'h1, {47'h0, oe_n});
  endtask
  // Writes stay shut until the first read
  task automatic t_gate;
    wr(5'h00, 16'h00AB);
    check("index", {3{16'h1234}}, idx);
    rd(5'h1C, 16'h0000);
    wr(5'h00, 16'h00AB);
    check("index", {32'h12341234, 16'h12AB}, idx);
  endtask
  // Shadow copies, a write through one lane reaching all, and reserved bits
  task automatic t_config;
    wr(5'h1D, 16'h000F);
    check("cfg", 48'hF, {44'h0, cfg});
    for (int a = 28; a < 32; a++) begin
      rd(a[4:0], 16'h000F);
    end
    wr(5'h1C, 16'h00F5);
    check("cfg", 48'h5, {44'h0, cfg});
    rd(5'h1E, 16'h0005);
  endtask
  // Big endian pair 0 swaps the byte lanes
  task automatic t_big;
    wr(5'h03, 16'h0077);
    wr(5'h00, 16'h0099);
    check("index", {32'h12341234, 16'h1277}, idx);
    rd(5'h01, 16'h0000);
    rd(5'h02, 16'h0012);
  endtask
  // Word mode with the enable strobe style
  task automatic t_wide;
    bus16 <= 1'h1;
    bus_enable_style <= 1'h1;
    wr(5'h08, 16'hBEEF);
    check("index", {16'h1234, 16'hBEEF, 16'h1277}, idx);
    rd(5'h09, 16'hBEEF);
    rd(5'h12, 16'h3412);
  endtask
  // Leaving D0 shuts writes until a read
  task automatic t_power;
    power_d0 <= 1'h0;
    wr(5'h08, 16'h1111);
    power_d0 <= 1'h1;
    wr(5'h08, 16'h2222);
    check("index", {16'h1234, 16'hBEEF, 16'h1277}, idx);
    rd(5'h08, 16'hBEEF);
    wr(5'h08, 16'h3333);
    check("index", {16'h1234, 16'h3333, 16'h1277}, idx);
  endtask
  // Reset in mid-run, then a read before init neither drives nor opens the gate
  task automatic t_init;
    logic [15:0] r;
    logic o;
    nrst_i <= 1'h0;
    init_done <= 1'h0;
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'h1;
    @(posedge sys_clk_i);
    check("index", {3{16'h1234}}, idx);
    check("cfg", 48'h0, {44'h0, cfg});
    host.access(1'h0, 5'h08, 16'h0000, r, o);
    check("dead oe_n", 48'h1, {47'h0, o});
    check("dead data", 48'h0, {32'h0, r});
    init_done <= 1'h1;
    wr(5'h08, 16'h4444);
    check("index", {3{16'h1234}}, idx);
    rd(5'h08, 16'h1234);
    wr(5'h08, 16'h4444);
    check("index", {16'h1234, 16'h4444, 16'h1234}, idx);
  endtask
  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk_i);
    nrst_i <= 1'h1;
    init_done <= 1'h1;
    @(posedge sys_clk_i);
    t_reset;
    t_gate;
    t_config;
    t_big;
    t_wide;
    t_power;
    t_init;
    finish_test;
  end
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #100us;
    mismatches++;
    finish_test;
  end
endmodule
